// file: src/lpdic_core.sv
// Device-side command state tracker with mode defaults and APB access.
// Assumes reset_n pin arrives asynchronously; APB master on pclk.
`timescale 1ns/10ps
// Summary of operation
// R01 - Activate picks bank, row; access picks column
// R02 - Sixteen-n core word, eight pin beats
// R03 - Bursts from column; only after initialization
// R04 - Self refresh allows powerdown, mode, multipurpose
// R05 - Idle means all banks precharged
// R06 - Training exits only by explicit command
// R07 - Automatic return goes to entering state
// R08 - Reset pin low forces reset state
// R09 - Latency and recovery fields default zero
// R10 - Inversion and termination default disabled
// R11 - Reference range one, code 001101, set 0
// R12 - Controller powers all channels together
// R13 - Outputs high impedance while reset low
// R14 - Controller holds reset first interval
// R15 - Gate low ten ns before reset release
// R16 - Gate waits, clock settles, select low
// R17 - Wait before first mode command
// R18 - Calibration start, wait, latch
// R19 - Command bus training after latch quiet
// R20 - Write leveling by leveling bit
// R21 - Data training leaves array untouched
// R22 - After training, accept any valid command; code refuses reads and writes until software sets init_done
// R23 - Reset 200 us, gate low 2 ms
// R24 - Five stable clocks before gate
// R25 - Two us before first mode command
// R26 - Latch quiet max 30 ns, 8 clocks
// R27 - Controller waits by rounded-up counters
module lpdic_core
	import lpdic_pkg::*;
#(
	parameter int NBANK = 8,
	parameter int DQW   = 16
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  reset_pin_n,
	input  wire logic [DQW-1:0]        dq_in,
	output logic      [DQW-1:0]        dq_out,
	output logic      [DQW-1:0]        dq_oe_n,
	output logic      [2:0]            bank_sel,
	output logic      [13:0]           row_sel,
	output logic      [9:0]            col_sel,
	output logic      [16*DQW-1:0]     core_word,
	output logic                       core_strobe
);
	// ****************************************
	// Reset pin synchroniser
	// ****************************************
	logic [2:0] rst_sync_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rst_sync_reg <= 3'h0;
		else
			rst_sync_reg <= {rst_sync_reg[1:0], reset_pin_n};
	end
	logic rst_level_reg;
	wire  rst_agree = rst_sync_reg[1] == rst_sync_reg[2];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rst_level_reg <= 1'b0;
		else if (rst_agree)
			rst_level_reg <= rst_sync_reg[2];
	end
	wire pin_rst = !rst_level_reg;
	// ****************************************
	// APB decode
	// ****************************************
	wire apb_wr   = psel && penable && pwrite;
	wire hit_ctrl = paddr == LPDIC_CTRL_OFF;
	wire hit_st   = paddr == LPDIC_STATE_OFF;
	wire hit_mr   = paddr == LPDIC_MRCFG_OFF;
	wire hit_vr   = paddr == LPDIC_VREF_OFF;
	wire hit_acc  = paddr == LPDIC_ACCESS_OFF;
	wire mapped   = hit_ctrl || hit_st || hit_mr || hit_vr || hit_acc;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	wire cmd_go = apb_wr && hit_ctrl;
	lpdic_cmd_t cmd;
	assign cmd = lpdic_cmd_t'(pwdata[LPDIC_CMD_LSB +: 4]);
	wire        trn_bit = pwdata[LPDIC_TRN_BIT];
	wire [2:0]  w_bank  = pwdata[LPDIC_BANK_LSB +: 3];
	wire [13:0] w_addr  = pwdata[LPDIC_ADDR_LSB +: 14];
	// ****************************************
	// Mode fields
	// ****************************************
	logic [1:0] fsp_reg;
	logic       wls_reg, lev_reg;
	logic [2:0] wl_reg, rl_reg, wrec_reg, command_bus_termination_reg, data_bus_termination_reg;
	logic [1:0] dbi_reg;
	logic       ca_rng_reg, dq_rng_reg;
	logic [5:0] ca_val_reg, dq_val_reg;
	wire mr_wr = apb_wr && hit_mr && !pin_rst;
	wire vr_wr = apb_wr && hit_vr && !pin_rst;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fsp_reg <= LPDIC_FSP_DEF; wls_reg <= LPDIC_WLS_DEF; lev_reg <= 1'b0; // [R11] [R09]
			wl_reg <= LPDIC_WL_DEF; rl_reg <= LPDIC_RL_DEF; wrec_reg <= LPDIC_WR_DEF; // [R09]
			dbi_reg <= LPDIC_DBI_DEF; command_bus_termination_reg <= LPDIC_ODT_DEF; data_bus_termination_reg <= LPDIC_ODT_DEF; // [R10]
			ca_rng_reg <= LPDIC_VRNG_DEF; dq_rng_reg <= LPDIC_VRNG_DEF; // [R11]
			ca_val_reg <= LPDIC_VVAL_DEF; dq_val_reg <= LPDIC_VVAL_DEF; // [R11]
		end else if (pin_rst) begin
			fsp_reg <= LPDIC_FSP_DEF; wls_reg <= LPDIC_WLS_DEF; lev_reg <= 1'b0; // [R08] [R09]
			wl_reg <= LPDIC_WL_DEF; rl_reg <= LPDIC_RL_DEF; wrec_reg <= LPDIC_WR_DEF; // [R09]
			dbi_reg <= LPDIC_DBI_DEF; command_bus_termination_reg <= LPDIC_ODT_DEF; data_bus_termination_reg <= LPDIC_ODT_DEF; // [R10]
			ca_rng_reg <= LPDIC_VRNG_DEF; dq_rng_reg <= LPDIC_VRNG_DEF; // [R11]
			ca_val_reg <= LPDIC_VVAL_DEF; dq_val_reg <= LPDIC_VVAL_DEF; // [R11]
		end else begin
			if (mr_wr) begin
				{lev_reg, wls_reg, wl_reg, rl_reg} <= pwdata[7:0]; // [R20]
				wrec_reg   <= pwdata[10:8];
				dbi_reg    <= pwdata[13:12];
				command_bus_termination_reg <= pwdata[18:16];
				data_bus_termination_reg <= pwdata[22:20];
				fsp_reg    <= pwdata[25:24];
			end
			if (vr_wr) begin
				{ca_rng_reg, ca_val_reg} <= pwdata[6:0];
				{dq_rng_reg, dq_val_reg} <= pwdata[14:8]; // [R21]
			end
		end
	end
	// Latency decode only for code zero; other codes are left to software
	wire [3:0] wl_cyc = wl_reg == LPDIC_WL_DEF ? LPDIC_WL_CYC : {1'b0, wl_reg};
	// ****************************************
	// Command state machine
	// ****************************************
	lpdic_state_t state_reg, state_next, ret_reg, ret_next;
	logic [NBANK-1:0] open_reg, open_next;
	logic [3:0]       cnt_reg, cnt_next;
	logic             init_done_reg;
	wire act_ok = state_reg == LPDIC_ST_IDLE || state_reg == LPDIC_ST_ACTIVE;
	always_comb begin
		state_next = state_reg;
		ret_next   = ret_reg;
		open_next  = open_reg;
		cnt_next   = cnt_reg == 4'h0 ? 4'h0 : cnt_reg - 4'h1;
		unique case (state_reg)
			LPDIC_ST_RESET: begin
				state_next = LPDIC_ST_IDLE;
			end
			LPDIC_ST_IDLE, LPDIC_ST_ACTIVE: begin
				if (cmd_go) begin
					if (cmd == LPDIC_CMD_ACT)
						open_next[w_bank] = 1'b1; // [R01]
					else if (cmd == LPDIC_CMD_PRE)
						open_next[w_bank] = 1'b0;
					else if ((cmd == LPDIC_CMD_RD || cmd == LPDIC_CMD_WR) && open_reg[w_bank] && init_done_reg) begin
						state_next = LPDIC_ST_BURST; // [R03]
						cnt_next   = 4'(LPDIC_BEATS - 1);
					end else if (cmd == LPDIC_CMD_MRW || cmd == LPDIC_CMD_MRR || cmd == LPDIC_CMD_MPC) begin
						state_next = trn_bit && cmd != LPDIC_CMD_MRR ? LPDIC_ST_TRAIN : LPDIC_ST_MODE; // [R06] [R19]
						ret_next   = state_reg; // [R07]
						cnt_next   = LPDIC_MODE_CYC;
					end else if (cmd == LPDIC_CMD_SRE && state_reg == LPDIC_ST_IDLE && open_reg == '0)
						state_next = LPDIC_ST_SREF;
					else if (cmd == LPDIC_CMD_PDE) begin
						state_next = LPDIC_ST_PDOWN;
						ret_next   = state_reg;
					end
				end
				if (state_next == state_reg)
					state_next = open_next == '0 ? LPDIC_ST_IDLE : LPDIC_ST_ACTIVE; // [R05]
			end
			LPDIC_ST_BURST: begin
				if (cnt_reg == 4'h0)
					state_next = LPDIC_ST_ACTIVE;
			end
			LPDIC_ST_MODE: begin
				if (cnt_reg == 4'h0)
					state_next = ret_reg; // [R07]
			end
			LPDIC_ST_TRAIN: begin
				if (cmd_go && cmd == LPDIC_CMD_TRN_EXIT)
					state_next = ret_reg; // [R06]
			end
			LPDIC_ST_SREF: begin
				if (cmd_go) begin
					if (cmd == LPDIC_CMD_SRX)
						state_next = LPDIC_ST_IDLE;
					else if (cmd == LPDIC_CMD_PDE || cmd == LPDIC_CMD_MRW || cmd == LPDIC_CMD_MRR ||
						cmd == LPDIC_CMD_MPC) begin
						state_next = cmd == LPDIC_CMD_PDE ? LPDIC_ST_PDOWN : LPDIC_ST_MODE; // [R04]
						ret_next   = LPDIC_ST_SREF;
						cnt_next   = LPDIC_MODE_CYC;
					end
				end
			end
			LPDIC_ST_PDOWN: begin
				if (cmd_go && cmd == LPDIC_CMD_PDX)
					state_next = ret_reg;
			end
			default: state_next = LPDIC_ST_RESET;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= LPDIC_ST_RESET;
			ret_reg   <= LPDIC_ST_IDLE;
			open_reg  <= '0;
			cnt_reg   <= 4'h0;
		end else if (pin_rst) begin
			state_reg <= LPDIC_ST_RESET; // [R08]
			ret_reg   <= LPDIC_ST_IDLE;
			open_reg  <= '0;
			cnt_reg   <= 4'h0;
		end else begin
			state_reg <= state_next;
			ret_reg   <= ret_next;
			open_reg  <= open_next;
			cnt_reg   <= cnt_next;
		end
	end
	// Initialization done is set by software once training is over
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			init_done_reg <= 1'b0;
		else if (pin_rst)
			init_done_reg <= 1'b0;
		else if (apb_wr && hit_st)
			init_done_reg <= pwdata[0]; // [R22]
	end
	// ****************************************
	// Address capture and data path
	// ****************************************
	wire col_go = cmd_go && act_ok && (cmd == LPDIC_CMD_RD || cmd == LPDIC_CMD_WR) && state_next == LPDIC_ST_BURST;
	wire row_go = cmd_go && act_ok && cmd == LPDIC_CMD_ACT;
	logic [16*DQW-1:0] word_reg;
	logic [2:0]        beat_reg;
	logic              wr_dir_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_sel <= 3'h0; row_sel <= 14'h0; col_sel <= 10'h0;
		end else if (row_go) begin
			bank_sel <= w_bank; row_sel <= w_addr; // [R01]
		end else if (col_go) begin
			bank_sel <= w_bank; col_sel <= {w_addr[9:2], 2'h0}; // [R01] [R03]
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_dir_reg <= 1'b0; beat_reg <= 3'h0; word_reg <= '0;
		end else if (col_go) begin
			wr_dir_reg <= cmd == LPDIC_CMD_WR; beat_reg <= 3'h0;
		end else if (state_reg == LPDIC_ST_BURST) begin
			beat_reg <= beat_reg + 3'h1;
			if (wr_dir_reg)
				word_reg[beat_reg*2*DQW +: 2*DQW] <= {dq_in, dq_in}; // [R02]
		end
	end
	wire burst_end = state_reg == LPDIC_ST_BURST && cnt_reg == 4'h0;
	// Read beat leads by one so data stands while the enable is low
	wire [2:0] beat_lead = col_go ? 3'h0 : beat_reg + 3'h1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_word <= '0; core_strobe <= 1'b0; dq_out <= '0;
		end else begin
			core_strobe <= burst_end; // [R02]
			// Last write beat lands on this same edge, so merge it here
			if (burst_end)
				core_word <= wr_dir_reg ? {dq_in, dq_in, word_reg[14*DQW-1:0]} : word_reg;
			dq_out <= word_reg[beat_lead*2*DQW +: DQW]; // [R02]
		end
	end
	wire drive_rd = state_reg == LPDIC_ST_BURST && !wr_dir_reg && !pin_rst;
	assign dq_oe_n = {DQW{!drive_rd}}; // [R13]
	// ****************************************
	// Read data
	// ****************************************
	wire [31:0] mr_rd = {6'h0, fsp_reg, 1'b0, data_bus_termination_reg, 1'b0, command_bus_termination_reg, 2'h0, dbi_reg, 1'b0, wrec_reg,
		lev_reg, wls_reg, wl_reg, rl_reg};
	wire [31:0] st_rd = {12'h0, wl_cyc, 8'(open_reg), state_reg, 3'h0, init_done_reg};
	wire [31:0] rd_mux = hit_mr  ? mr_rd :
		hit_vr  ? {17'h0, dq_rng_reg, dq_val_reg, 1'b0, ca_rng_reg, ca_val_reg} :
		hit_st  ? st_rd :
		hit_acc ? {5'h0, row_sel, 3'h0, col_sel} :
		hit_ctrl ? {!pin_rst, 31'h0} : 32'h0;
	assign prdata = rd_mux;
	// ****************************************
	// Checks
	// ****************************************
	a_reset_state_entry: assert property (@(posedge pclk) disable iff (!presetn) pin_rst |=> state_reg == LPDIC_ST_RESET) else $error("reset state missed"); // [R08]
	a_hiz_in_reset: assert property (@(posedge pclk) disable iff (!presetn) pin_rst |-> &dq_oe_n) else $error("driving in reset"); // [R13]
	a_idle_precharged: assert property (@(posedge pclk) disable iff (!presetn) state_reg == LPDIC_ST_IDLE |-> open_reg == '0) else $error("idle with open bank"); // [R05]
	a_mode_return: assert property (@(posedge pclk) disable iff (!presetn || pin_rst) state_reg != LPDIC_ST_MODE ##1 state_reg == LPDIC_ST_MODE |-> ##5 state_reg == $past(ret_reg, 5)) else $error("mode no return"); // [R07]
	a_train_stays: assert property (@(posedge pclk) disable iff (!presetn || pin_rst) state_reg == LPDIC_ST_TRAIN && !(cmd_go && cmd == LPDIC_CMD_TRN_EXIT) |=> state_reg == LPDIC_ST_TRAIN) else $error("training left"); // [R06]
	a_default_fields: assert property (@(posedge pclk) disable iff (!presetn) $fell(pin_rst) |-> wl_reg == 3'h0 && rl_reg == 3'h0 && wrec_reg == 3'h0 && wl_cyc == LPDIC_WL_CYC) else $error("latency defaults"); // [R09]
	a_odt_defaults: assert property (@(posedge pclk) disable iff (!presetn) $fell(pin_rst) |-> dbi_reg == 2'h0 && command_bus_termination_reg == 3'h0 && data_bus_termination_reg == 3'h0) else $error("odt defaults"); // [R10]
	a_vref_defaults: assert property (@(posedge pclk) disable iff (!presetn) $fell(pin_rst) |-> ca_rng_reg && ca_val_reg == 6'h0d && dq_val_reg == 6'h0d && fsp_reg == 2'h0) else $error("vref defaults"); // [R11]
	a_burst_length: assert property (@(posedge pclk) disable iff (!presetn || pin_rst) col_go |=> state_reg == LPDIC_ST_BURST [*8] ##1 state_reg != LPDIC_ST_BURST) else $error("burst length"); // [R02]
	a_sref_exits: assert property (@(posedge pclk) disable iff (!presetn || pin_rst) state_reg == LPDIC_ST_SREF |=> state_reg inside {LPDIC_ST_SREF, LPDIC_ST_IDLE, LPDIC_ST_PDOWN, LPDIC_ST_MODE}) else $error("sref exit"); // [R04]
endmodule : lpdic_core

// file: src/lpdic_pkg.sv
// Package: constants for the device-side command state and init tracker.
// Assumes one clock pclk at 125 MHz and an APB master for register access.
package lpdic_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] LPDIC_CTRL_OFF   = 8'h00;
	localparam logic [7:0] LPDIC_STATE_OFF  = 8'h04;
	localparam logic [7:0] LPDIC_MRCFG_OFF  = 8'h08;
	localparam logic [7:0] LPDIC_VREF_OFF   = 8'h0c;
	localparam logic [7:0] LPDIC_ACCESS_OFF = 8'h10;
	// ****************************************
	// Mode field defaults after reset
	// ****************************************
	localparam logic [1:0] LPDIC_FSP_DEF    = 2'h0;
	localparam logic       LPDIC_WLS_DEF    = 1'h0;
	localparam logic [2:0] LPDIC_WL_DEF     = 3'h0;
	localparam logic [2:0] LPDIC_RL_DEF     = 3'h0;
	localparam logic [2:0] LPDIC_WR_DEF     = 3'h0;
	localparam logic [1:0] LPDIC_DBI_DEF    = 2'h0;
	localparam logic [2:0] LPDIC_ODT_DEF    = 3'h0;
	localparam logic       LPDIC_VRNG_DEF   = 1'h1;
	localparam logic [5:0] LPDIC_VVAL_DEF   = 6'h0d;
	// Decoded latency figures at default field codes
	localparam logic [3:0] LPDIC_WL_CYC     = 4'h4;
	localparam logic [3:0] LPDIC_RL_CYC     = 4'h6;
	localparam logic [3:0] LPDIC_RTP_CYC    = 4'h8;
	localparam logic [3:0] LPDIC_WREC_CYC   = 4'h6;
	// ****************************************
	// Prefetch and burst
	// ****************************************
	localparam int LPDIC_PREFETCH = 16;
	localparam int LPDIC_BEATS    = 8;
	// ****************************************
	// Command codes written by software
	// ****************************************
	typedef enum logic [3:0] {
		LPDIC_CMD_NOP      = 4'h0,
		LPDIC_CMD_ACT      = 4'h1,
		LPDIC_CMD_RD       = 4'h2,
		LPDIC_CMD_WR       = 4'h3,
		LPDIC_CMD_PRE      = 4'h4,
		LPDIC_CMD_MRW      = 4'h5,
		LPDIC_CMD_MRR      = 4'h6,
		LPDIC_CMD_MPC      = 4'h7,
		LPDIC_CMD_SRE      = 4'h8,
		LPDIC_CMD_SRX      = 4'h9,
		LPDIC_CMD_PDE      = 4'ha,
		LPDIC_CMD_PDX      = 4'hb,
		LPDIC_CMD_TRN_EXIT = 4'hc
	} lpdic_cmd_t;
	typedef enum logic [3:0] {
		LPDIC_ST_RESET  = 4'h0,
		LPDIC_ST_IDLE   = 4'h1,
		LPDIC_ST_ACTIVE = 4'h2,
		LPDIC_ST_BURST  = 4'h3,
		LPDIC_ST_MODE   = 4'h4,
		LPDIC_ST_TRAIN  = 4'h5,
		LPDIC_ST_SREF   = 4'h6,
		LPDIC_ST_PDOWN  = 4'h7
	} lpdic_state_t;
	// CTRL register fields
	localparam int LPDIC_CMD_LSB   = 0;
	localparam int LPDIC_TRN_BIT   = 4;
	localparam int LPDIC_BANK_LSB  = 8;
	localparam int LPDIC_ADDR_LSB  = 12;
	localparam int LPDIC_RDY_BIT   = 31;
	// Counter load of the automatic-return mode state, which lasts five cycles
	localparam logic [3:0] LPDIC_MODE_CYC = 4'h4;
endpackage : lpdic_pkg

// file: bench/lpdic_ctrl_model.sv
// Controller-side model: drives the device reset pin and the write data pins.
// Assumes pclk from the bench; a go_reset pulse starts a fresh reset hold.
`timescale 1ns/10ps
module lpdic_ctrl_model
	import lpdic_pkg::*;
#(
	parameter int HOLD_CYC = 40,
	parameter int DQW      = 16
) (
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire logic      go_reset,
	output logic           reset_pin_n,
	output logic [DQW-1:0] dq_in
);
	// ****************************************
	// Reset pin hold
	// ****************************************
	logic [15:0] hold_reg;
	// Scaled hold; the true interval would dwarf the run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hold_reg <= 16'h0000;
		else if (go_reset) hold_reg <= 16'h0000;
		else if (hold_reg != HOLD_CYC[15:0]) hold_reg <= hold_reg + 16'h0001;
	end
	assign reset_pin_n = (hold_reg == HOLD_CYC[15:0]);
	// Data lines change every cycle, never parked at a stale value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) dq_in <= {DQW{1'b1}};
		else dq_in <= {dq_in[DQW-2:0], dq_in[DQW-1] ^ dq_in[DQW-2]};
	end
endmodule : lpdic_ctrl_model

// file: bench/lpdic_core_tb.sv
// Testbench: APB master, controller model and state checks for lpdic_core.
// Assumes the watchdog bounds every wait; pin hold scaled down.
`timescale 1ns/10ps
module lpdic_core_tb
	import lpdic_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_pin_n, core_strobe, go_reset;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, r;
	logic [15:0]  dq_in, dq_out, dq_oe_n;
	logic [2:0]   bank_sel, bank;
	logic [13:0]  row_sel, row;
	logic [9:0]   col_sel, col;
	logic [255:0] core_word;
	logic         e;
	logic         wr_mode = 1'b0;
	logic [127:0] dq_hist;
	logic [255:0] last_word = '0, exp_word;
	int failures, tests_run, oe_cnt, stb_cnt;
	logic [31:0] seed = 32'h00000032;
	lpdic_core #(.NBANK(8), .DQW(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reset_pin_n(reset_pin_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .bank_sel(bank_sel),
		.row_sel(row_sel), .col_sel(col_sel), .core_word(core_word), .core_strobe(core_strobe));
	lpdic_ctrl_model #(.HOLD_CYC(40), .DQW(16)) ctrl_u (.pclk(pclk), .presetn(presetn), .go_reset(go_reset),
		.reset_pin_n(reset_pin_n), .dq_in(dq_in));
	// ****************************************
	// Helpers
	// ****************************************
	initial begin pclk = 0; forever #4 pclk = ~pclk; end
	always @(posedge pclk) begin
		dq_hist <= {dq_hist[111:0], dq_in};
		if (dq_oe_n === 16'h0000) begin
			check({16'h0, dq_out}, {16'h0, last_word[oe_cnt*32 +: 16]}, "read beat");
			oe_cnt++;
		end
		if (core_strobe === 1'b1) begin
			stb_cnt++;
			exp_word = wr_mode ? pack_beats(dq_hist) : last_word;
			for (int k = 0; k < 8; k++) check(core_word[k*32 +: 32], exp_word[k*32 +: 32], "core word");
			last_word = exp_word;
		end
	end
	// Beat k is the pin value sampled k cycles into the burst, sent twice
	function automatic logic [255:0] pack_beats(input logic [127:0] h);
		logic [255:0] w;
		w = '0;
		for (int k = 0; k < 8; k++) w[k*32 +: 32] = {2{h[(7-k)*16 +: 16]}};
		return w;
	endfunction : pack_beats
	function automatic logic [31:0] xs();
		seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [31:0] cw(input lpdic_cmd_t c, input logic t, input logic [2:0] b, input logic [13:0] a);
		return {6'h00, a, 1'b0, b, 3'h0, t, c};
	endfunction : cw
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	// Master holds every request signal until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic st(output logic [3:0] s);
		apb(1'b0, LPDIC_STATE_OFF, 32'h0);
		s = r[7:4];
	endtask : st
	task automatic wait_st(input lpdic_state_t x, output logic [3:0] s);
		int n;
		for (n = 0; n < 60; n++) begin st(s); if (s === x) break; end
	endtask : wait_st
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	initial begin #200000; failures++; $display("mismatch at %0t: run hung", $time); conclude(); end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin : main
		logic [3:0] s;
		int i;
		logic [31:0] mv;
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; go_reset = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, LPDIC_MRCFG_OFF, 32'h0); check(r, 32'h0, "mode defaults");
		apb(1'b0, LPDIC_VREF_OFF, 32'h0); check(r, 32'h00004d4d, "reference defaults");
		apb(1'b0, LPDIC_STATE_OFF, 32'h0); check({28'h0, r[19:16]}, {28'h0, LPDIC_WL_CYC}, "wl");
		check({28'h0, r[7:4]}, {28'h0, LPDIC_ST_RESET}, "held in reset");
		check({16'h0, dq_oe_n}, 32'h0000ffff, "outputs off in reset");
		wait_st(LPDIC_ST_IDLE, s); check({28'h0, s}, {28'h0, LPDIC_ST_IDLE}, "idle after pin");
		apb(1'b0, LPDIC_CTRL_OFF, 32'h0); check({31'h0, r[31]}, 32'h1, "pin released");
		$display("test defaults done");
		// Scaled boot; gate and clock timing are not pins of this block
		repeat (8) @(posedge pclk);
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_MPC, 1'b0, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_MODE}, "calibration start");
		repeat (10) @(posedge pclk);
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_MPC, 1'b0, 3'h0, 14'h1));
		repeat (10) @(posedge pclk);
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_IDLE}, "latch quiet");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_MRW, 1'b1, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_TRAIN}, "command training");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_TRN_EXIT, 1'b0, 3'h0, 14'h0));
		apb(1'b1, LPDIC_MRCFG_OFF, 32'h00000080);
		apb(1'b0, LPDIC_MRCFG_OFF, 32'h0); check(r, 32'h00000080, "leveling bit");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_MPC, 1'b1, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_TRAIN}, "data training");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_TRN_EXIT, 1'b0, 3'h0, 14'h0));
		mv = xs() & 32'h00007f7f;
		apb(1'b1, LPDIC_VREF_OFF, mv);
		apb(1'b0, LPDIC_VREF_OFF, 32'h0); check(r, mv, "reference write");
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_IDLE}, "ready");
		$display("test boot done");
		// Access before init_done must be ignored
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_ACT, 1'b0, 3'h2, 14'h0011));
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_RD, 1'b0, 3'h2, 14'h0000));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_ACTIVE}, "read refused");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_PRE, 1'b0, 3'h2, 14'h0));
		apb(1'b1, LPDIC_STATE_OFF, 32'h1);
		for (i = 0; i < 6; i++) begin
			{bank, row, col} = 27'(xs());
			if (i == 0) {bank, row, col} = {3'h7, 14'h3fff, 10'h3ff};
			apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_ACT, 1'b0, bank, row));
			check({29'h0, bank_sel}, {29'h0, bank}, "bank");
			check({18'h0, row_sel}, {18'h0, row}, "row");
			oe_cnt = 0; stb_cnt = 0; wr_mode = i[0];
			apb(1'b1, LPDIC_CTRL_OFF, cw(i[0] ? LPDIC_CMD_WR : LPDIC_CMD_RD, 1'b0, bank, {4'h0, col}));
			repeat (14) @(posedge pclk);
			check({22'h0, col_sel}, {22'h0, col[9:2], 2'h0}, "column");
			check(oe_cnt, i[0] ? 0 : LPDIC_BEATS, "read beats");
			check(stb_cnt, 1, "core word");
			st(s); check({28'h0, s}, {28'h0, LPDIC_ST_ACTIVE}, "burst end");
			apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_PRE, 1'b0, bank, 14'h0));
		end
		$display("test access done");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_ACT, 1'b0, 3'h1, 14'h0005));
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_MRW, 1'b0, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_MODE}, "mode entered");
		repeat (10) @(posedge pclk);
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_ACTIVE}, "mode back to active");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_PRE, 1'b0, 3'h1, 14'h0));
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_MRW, 1'b1, 3'h0, 14'h0));
		repeat (20) @(posedge pclk);
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_TRAIN}, "training stays");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_TRN_EXIT, 1'b0, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_IDLE}, "training exit");
		$display("test mode done");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_SRE, 1'b0, 3'h0, 14'h0));
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_MRR, 1'b0, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_MODE}, "read mode from sref");
		repeat (10) @(posedge pclk);
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_SREF}, "back to sref");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_PDE, 1'b0, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_PDOWN}, "powerdown from sref");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_PDX, 1'b0, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_SREF}, "powerdown back to sref");
		apb(1'b1, LPDIC_CTRL_OFF, cw(LPDIC_CMD_SRX, 1'b0, 3'h0, 14'h0));
		st(s); check({28'h0, s}, {28'h0, LPDIC_ST_IDLE}, "sref exit");
		$display("test self refresh done");
		mv = xs() & 32'h0377f7ff | 32'h1;
		apb(1'b1, LPDIC_MRCFG_OFF, mv);
		apb(1'b0, LPDIC_MRCFG_OFF, 32'h0); check(r, mv & 32'h037737ff, "mode write");
		go_reset <= 1'b1;
		@(posedge pclk);
		go_reset <= 1'b0;
		wait_st(LPDIC_ST_RESET, s); check({28'h0, s}, {28'h0, LPDIC_ST_RESET}, "pin reset");
		check({16'h0, dq_oe_n}, 32'h0000ffff, "outputs off");
		apb(1'b0, LPDIC_MRCFG_OFF, 32'h0); check(r, 32'h0, "defaults again");
		apb(1'b0, LPDIC_VREF_OFF, 32'h0); check(r, 32'h00004d4d, "reference again");
		wait_st(LPDIC_ST_IDLE, s); check({28'h0, s}, {28'h0, LPDIC_ST_IDLE}, "idle again");
		apb(1'b0, 8'h20, 32'h0); check({31'h0, e}, 32'h1, "unmapped");
		apb(1'b0, LPDIC_ACCESS_OFF, 32'h0); check({31'h0, e}, 32'h0, "mapped");
		$display("test reset pin done");
		conclude();
	end
endmodule : lpdic_core_tb
